/* File: rtl/host_memory_port.sv */
// Purpose: host memory port: base decode, shared and code RAM, control regs, host irq
// Assumes: host strobes and address synchronous to clk; one access per strobe level
// Notes:   host strobes active low; access acted on at strobe start (one-cycle edge)
//
// Overview of operation
// - shared RAM byte zero sits at host base and embedded data address zero
// - code RAM sits at base plus 0x1000, embedded program address zero there
// - base jumpers map to segment byte via fixed table; upper six bits used
// - six base bits compared with top six host address bits for selection
// - host reaches code RAM only while embedded processor is held in reset
// - host reaches shared RAM whenever base matches, running or in reset
// - transfer needs chip enable low plus read or write strobe
// - host writes to offsets 0 and 1 load the control registers; writes to 0..3 also land in shared RAM
// - embedded writes to offsets 0..3 touch only shared RAM
// - reads of offsets 0..3 return shared RAM contents, not registers
// - run bit zero holds embedded processor in reset, one releases it
// - host interrupt enable bit zero blocks interrupts, one allows them
// - user mode bits appear on embedded port 1 bits 1 and 2
// - line select low nibble picks the single host interrupt line driven
// - line select bit 4 gates interrupts with master enable; upper bits zero
// - embedded write to 0xFFE interrupts host when both registers enable it
// - host interrupt is one low pulse on the open-drain selected line
// - after a pulse, further pulses locked until host reads 0xFFE
// - bus reset high forces reset; stays reset until run bit set
// - host code RAM window is base plus 0x1000 through 0x2FFF
// - embedded processor fetches from code RAM address zero after release
`timescale 1ns/100ps
`default_nettype none
module host_memory_port #(
  parameter int IRQ_PULSE = host_port_pkg::IRQ_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        bus_reset_input,
  // host bus
  input  wire logic [19:0] host_addr,
  input  wire logic        chip_enable_n,
  input  wire logic        mem_read_n,
  input  wire logic        mem_write_n,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             host_data_oe_n,
  input  wire logic [3:0]  base_jumper_inputs,
  // host interrupt lines, open drain: output always low, enable low drives
  output logic      [15:0] irq_line_out,
  output logic      [15:0] irq_line_oe_n,
  // embedded processor side
  output logic             core_reset,
  input  wire logic [12:0] core_code_addr,
  output logic      [7:0]  core_code_data,
  input  wire logic [11:0] core_data_addr,
  input  wire logic        core_data_write,
  input  wire logic [7:0]  core_data_wdata,
  output logic      [7:0]  core_data_rdata,
  output logic             port1_bit1_input,
  output logic             port1_bit2_input
);
  typedef enum logic [1:0] {
    IRQ_IDLE   = 2'b00,
    IRQ_PULSE_ST  = 2'b01,
    IRQ_LOCKED = 2'b10
  } irq_state_type;

  ////////////////////////////////////////////////////////////////////////
  // base decode

  function automatic logic [7:0] base_segment(input logic [3:0] sel);
    case (sel)
      4'h0: base_segment = 8'h00;
      4'h1: base_segment = 8'hA4;
      4'h2: base_segment = 8'hA8;
      4'h3: base_segment = 8'hAC;
      4'h4: base_segment = 8'hB0;
      4'h5: base_segment = 8'hB4;
      4'h6: base_segment = 8'hC8;
      4'h7: base_segment = 8'hCC;
      4'h8: base_segment = 8'hD0;
      4'h9: base_segment = 8'hD4;
      4'hA: base_segment = 8'hD8;
      4'hB: base_segment = 8'hDC;
      4'hC: base_segment = 8'hE0;
      4'hD: base_segment = 8'hE4;
      4'hE: base_segment = 8'hE8;
      default: base_segment = 8'hEC;
    endcase
  endfunction

  logic [7:0]  master_control;
  logic [7:0]  interrupt_line_select;
  logic        run_latched;
  logic        rd_q;
  logic        wr_q;
  irq_state_type irq_state;
  logic [15:0] pulse_count;

  wire [7:0]  segment     = base_segment(base_jumper_inputs);
  wire [5:0]  active_base = segment[7:2];
  wire        base_match  = (host_addr[19:14] == active_base);
  wire [13:0] host_offset = host_addr[13:0];
  wire        rd_active   = !chip_enable_n && !mem_read_n && base_match;
  wire        wr_active   = !chip_enable_n && !mem_write_n && base_match;
  wire        rd_start    = rd_active && !rd_q;
  wire        wr_start    = wr_active && !wr_q;
  wire        in_shared   = (host_offset <= host_port_pkg::SHARED_WINDOW_END);
  wire        in_code     = (host_offset >= host_port_pkg::CODE_WINDOW_START)
                            && (host_offset <= host_port_pkg::CODE_WINDOW_END);
  wire [11:0] shared_ofs  = host_offset[11:0];
  wire [12:0] code_ofs    = 13'(host_offset - host_port_pkg::CODE_WINDOW_START);
  wire        code_open   = in_code && core_reset;
  wire        host_sh_wr  = wr_start && in_shared;
  wire        host_cd_wr  = wr_start && code_open;
  wire        ctrl_write  = host_sh_wr && (shared_ofs <= host_port_pkg::CTRL_LAST_OFS);

  ////////////////////////////////////////////////////////////////////////
  // control registers, host-writable only

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      master_control        <= host_port_pkg::CTRL_RESET_VALUE;
      interrupt_line_select <= host_port_pkg::SEL_RESET_VALUE;
    end else if (bus_reset_input) begin
      // bus reset clears run bit so the core stays held afterwards
      master_control        <= host_port_pkg::CTRL_RESET_VALUE;
    end else if (ctrl_write) begin
      if (shared_ofs == host_port_pkg::MASTER_CONTROL_OFS) begin
        master_control <= host_wdata;
      end
      if (shared_ofs == host_port_pkg::LINE_SELECT_OFS) begin
        interrupt_line_select <= host_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_latched <= 1'b0;
    end else begin
      run_latched <= master_control[host_port_pkg::RUN_RELEASE_BIT] && !bus_reset_input;
    end
  end

  assign core_reset       = !run_latched;
  assign port1_bit1_input = master_control[host_port_pkg::USER_MODE_A_BIT];
  assign port1_bit2_input = master_control[host_port_pkg::USER_MODE_B_BIT];

  ////////////////////////////////////////////////////////////////////////
  // memories

  logic [7:0] host_sh_rdata;
  logic [7:0] host_cd_rdata;
  logic [7:0] code_mem [0:(1<<host_port_pkg::CODE_ADDR_W)-1];

  // host is port a so it wins a same-byte collision
  dual_port_byte_ram #(
    .ADDR_W (host_port_pkg::SHARED_ADDR_W),
    .DATA_W (host_port_pkg::DATA_W)
  ) shared_ram (
    .clk     (clk),
    .a_write (host_sh_wr),
    .a_addr  (shared_ofs),
    .a_wdata (host_wdata),
    .a_rdata (host_sh_rdata),
    .b_write (core_data_write),
    .b_addr  (core_data_addr),
    .b_wdata (core_data_wdata),
    .b_rdata (core_data_rdata)
  );

  // code port: host only during reset, core reads at all times
  always_ff @(posedge clk) begin
    if (host_cd_wr) begin
      code_mem[code_ofs] <= host_wdata;
    end
    host_cd_rdata  <= code_mem[code_ofs];
    core_code_data <= code_mem[core_code_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // host read data path

  logic       rd_shared_q;
  logic       rd_code_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      rd_shared_q <= 1'b0;
      rd_code_q   <= 1'b0;
    end else begin
      rd_q        <= rd_active;
      wr_q        <= wr_active;
      rd_shared_q <= rd_active && in_shared;
      rd_code_q   <= rd_active && code_open;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata <= 8'h00;
    end else if (rd_shared_q) begin
      host_rdata <= host_sh_rdata;
    end else if (rd_code_q) begin
      host_rdata <= host_cd_rdata;
    end
  end

  // drive bus while a decoded read is in progress
  assign host_data_oe_n = !((rd_shared_q || rd_code_q) && rd_active);

  ////////////////////////////////////////////////////////////////////////
  // host interrupt

  wire ctrl_irq_ok = ((master_control & host_port_pkg::CTRL_INT_MASK)
                      == host_port_pkg::CTRL_INT_VALUE);
  wire sel_irq_ok  = (interrupt_line_select[7:4] == host_port_pkg::SEL_GATE_VALUE);
  wire core_irq_wr = core_data_write
                     && (core_data_addr == host_port_pkg::HOST_INT_REQ_OFS);
  wire host_irq_rd = rd_start && in_shared
                     && (shared_ofs == host_port_pkg::HOST_INT_REQ_OFS);
  wire pulse_done  = (pulse_count == 16'(IRQ_PULSE - 1));

  // a host read during the pulse still unlocks once the pulse ends
  logic read_seen;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_state   <= IRQ_IDLE;
      pulse_count <= 16'h0000;
      read_seen   <= 1'b0;
    end else begin
      case (irq_state)
        IRQ_IDLE: begin
          pulse_count <= 16'h0000;
          read_seen   <= 1'b0;
          if (core_irq_wr && ctrl_irq_ok && sel_irq_ok) begin
            irq_state <= IRQ_PULSE_ST;
          end
        end
        IRQ_PULSE_ST: begin
          pulse_count <= pulse_count + 16'h0001;
          if (host_irq_rd) begin
            read_seen <= 1'b1;
          end
          if (pulse_done) begin
            irq_state <= (read_seen || host_irq_rd) ? IRQ_IDLE : IRQ_LOCKED;
          end
        end
        IRQ_LOCKED: begin
          if (host_irq_rd) begin
            irq_state <= IRQ_IDLE;
          end
        end
        default: irq_state <= IRQ_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < host_port_pkg::IRQ_LINES; g = g + 1) begin : g_irq
      assign irq_line_out[g]  = 1'b0;
      assign irq_line_oe_n[g] = !((irq_state == IRQ_PULSE_ST)
                                  && (interrupt_line_select[3:0] == 4'(g)));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // checks

  // a code window read while running must never turn the bus around
  property p_code_locked;
    @(posedge clk) disable iff (!nrst)
    !core_reset && rd_active && in_code |=> host_data_oe_n;
  endproperty
  a_code_locked: assert property (p_code_locked) else $error("code read while running");

  property p_pulse_cause;
    @(posedge clk) disable iff (!nrst)
    $rose(irq_state == IRQ_PULSE_ST) |-> $past(core_irq_wr && ctrl_irq_ok && sel_irq_ok);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without cause");

  property p_one_line;
    @(posedge clk) disable iff (!nrst)
    $onehot0(~irq_line_oe_n);
  endproperty
  a_one_line: assert property (p_one_line) else $error("more than one irq line");

  property p_lock_holds;
    @(posedge clk) disable iff (!nrst)
    (irq_state == IRQ_LOCKED) && !host_irq_rd |=> (irq_state == IRQ_LOCKED);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock dropped early");

  property p_run_release;
    @(posedge clk) disable iff (!nrst)
    !master_control[host_port_pkg::RUN_RELEASE_BIT] |=> core_reset;
  endproperty
  a_run_release: assert property (p_run_release) else $error("core ran with run bit low");

  property p_bus_reset;
    @(posedge clk) disable iff (!nrst)
    bus_reset_input |=> core_reset [*2];
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("core out of reset on bus reset");

  property p_ctrl_host_only;
    @(posedge clk) disable iff (!nrst)
    !ctrl_write && !bus_reset_input |=> $stable(interrupt_line_select);
  endproperty
  a_ctrl_host_only: assert property (p_ctrl_host_only) else $error("select changed");

  property p_no_sel_no_access;
    @(posedge clk) disable iff (!nrst)
    !base_match |=> !rd_shared_q && !rd_code_q;
  endproperty
  a_no_sel_no_access: assert property (p_no_sel_no_access) else $error("unselected read");

  property p_mode_bits;
    @(posedge clk) disable iff (!nrst)
    ctrl_write && shared_ofs == host_port_pkg::MASTER_CONTROL_OFS && !bus_reset_input
      |=> port1_bit1_input == $past(host_wdata[host_port_pkg::USER_MODE_A_BIT])
          && port1_bit2_input == $past(host_wdata[host_port_pkg::USER_MODE_B_BIT]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits wrong");
endmodule // host_memory_port
`default_nettype wire

/* File: shared/host_port_pkg.sv */
// Purpose: constants for the shared-RAM host memory port
// Assumes: 20-bit host address, 8-bit data, 4 KiB shared RAM, 8 KiB code RAM
// Notes:   offsets are host offsets from the selected base
package host_port_pkg;
  localparam int          HOST_ADDR_W        = 20;
  localparam int          DATA_W             = 8;
  localparam int          SHARED_ADDR_W      = 12;
  localparam int          CODE_ADDR_W        = 13;
  localparam int          BASE_BITS          = 6;
  localparam int          IRQ_LINES          = 16;
  // host offset windows
  localparam logic [13:0] CODE_WINDOW_START  = 14'h1000;
  localparam logic [13:0] CODE_WINDOW_END    = 14'h2FFF;
  localparam logic [13:0] SHARED_WINDOW_END  = 14'h0FFF;
  // register offsets within shared RAM
  localparam logic [11:0] MASTER_CONTROL_OFS = 12'h000;
  localparam logic [11:0] LINE_SELECT_OFS    = 12'h001;
  localparam logic [11:0] CTRL_LAST_OFS      = 12'h003;
  localparam logic [11:0] HOST_INT_REQ_OFS   = 12'hFFE;
  // master control fields
  localparam int          RUN_RELEASE_BIT    = 0;
  localparam int          USER_MODE_A_BIT    = 1;
  localparam int          USER_MODE_B_BIT    = 2;
  localparam int          HOST_INT_EN_BIT    = 3;
  localparam int          CODE_ACCESS_EN_BIT = 4;
  // interrupt enable patterns: 0001 1xx1 and 0001 N
  localparam logic [7:0]  CTRL_INT_MASK      = 8'hF9;
  localparam logic [7:0]  CTRL_INT_VALUE     = 8'h19;
  localparam logic [3:0]  SEL_GATE_VALUE     = 4'h1;
  localparam logic [7:0]  CTRL_RESET_VALUE   = 8'h00;
  localparam logic [7:0]  SEL_RESET_VALUE    = 8'h00;
  // host interrupt pulse length
  localparam int          CLK_PERIOD_PS      = 4000;
  localparam int          IRQ_PULSE_NS       = 100;
  localparam int          IRQ_PULSE_CYCLES   = (IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
endpackage

/* File: rtl/dual_port_byte_ram.sv */
// Purpose: byte RAM with two synchronous read/write ports
// Assumes: port a wins when both write the same byte in one cycle
// Notes:   read data appears one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module dual_port_byte_ram #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // clock
  input  wire logic              clk,
  // port a
  input  wire logic              a_write,
  input  wire logic [ADDR_W-1:0] a_addr,
  input  wire logic [DATA_W-1:0] a_wdata,
  output logic      [DATA_W-1:0] a_rdata,
  // port b
  input  wire logic              b_write,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [DATA_W-1:0] b_wdata,
  output logic      [DATA_W-1:0] b_rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  wire b_blocked = a_write && (a_addr == b_addr);

  always_ff @(posedge clk) begin
    if (a_write) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_write && !b_blocked) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule // dual_port_byte_ram
`default_nettype wire

/* File: verif/host_bus_model.sv */
// Purpose: behavioural host processor on the shared-RAM memory bus
// Assumes: strobes active low, changed 1 ns after the rising edge
// Notes:   released address and data lines show the inverse of their last value; strobes go high
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  // clock
  input  wire logic        clk,
  // host bus
  output logic      [19:0] host_addr,
  output logic             chip_enable_n,
  output logic             mem_read_n,
  output logic             mem_write_n,
  output logic      [7:0]  host_wdata,
  input  wire logic [7:0]  host_rdata,
  input  wire logic        host_data_oe_n
);
  logic oe_seen;
  initial begin
    host_addr     = 20'h00000;
    host_wdata    = 8'h00;
    chip_enable_n = 1'b1;
    mem_read_n    = 1'b1;
    mem_write_n   = 1'b1;
    oe_seen       = 1'b0;
  end
  // whole byte per strobe; reads held four edges so data has settled
  task automatic access(input logic [19:0] a, input logic wr, input logic [7:0] d,
                        input logic ce_n, output logic [7:0] q);
    @(posedge clk);
    #1;
    host_addr     = a;
    host_wdata    = d;
    chip_enable_n = ce_n;
    mem_write_n   = !wr;
    mem_read_n    = wr;
    oe_seen       = 1'b0;
    repeat (wr ? 1 : 4) begin
      @(posedge clk);
      if (host_data_oe_n === 1'b0) oe_seen = 1'b1;
    end
    q = host_rdata;
    #1;
    mem_write_n   = 1'b1;
    mem_read_n    = 1'b1;
    chip_enable_n = 1'b1;
    host_addr     = ~a;
    host_wdata    = ~d;
  endtask
endmodule // host_bus_model
`default_nettype wire

/* File: verif/isa_shared_ram_host_port_test.sv */
// Purpose: self-checking bench for the host memory port
// Assumes: host driven by host_bus_model, core side driven here
// Notes:   short irq pulse parameter keeps the run brief
`timescale 1ns/100ps
`default_nettype none
module isa_shared_ram_host_port_test;
  localparam int PULSE = 4;
  logic        clk, nrst, bus_reset_input, chip_enable_n, mem_read_n, mem_write_n;
  logic        host_data_oe_n, core_reset, core_data_write, port1_bit1_input;
  logic        port1_bit2_input;
  logic [19:0] host_addr, base;
  logic [15:0] irq_line_out, irq_line_oe_n;
  logic [12:0] core_code_addr;
  logic [11:0] core_data_addr;
  logic [7:0]  host_wdata, host_rdata, core_code_data, core_data_wdata, core_data_rdata, q;
  logic [3:0]  base_jumper_inputs;
  int          fails, n_compared;
  logic [7:0]  seg_tab [16] = '{8'h00, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hC8, 8'hCC,
                                8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'hE4, 8'hE8, 8'hEC};
  host_memory_port #(.IRQ_PULSE(PULSE)) dut (.clk, .nrst, .bus_reset_input, .host_addr,
    .chip_enable_n, .mem_read_n, .mem_write_n, .host_wdata, .host_rdata, .host_data_oe_n,
    .base_jumper_inputs, .irq_line_out, .irq_line_oe_n, .core_reset, .core_code_addr,
    .core_code_data, .core_data_addr, .core_data_write, .core_data_wdata, .core_data_rdata,
    .port1_bit1_input, .port1_bit2_input);
  host_bus_model hm (.clk, .host_addr, .chip_enable_n, .mem_read_n, .mem_write_n,
    .host_wdata, .host_rdata, .host_data_oe_n);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hw(input logic [19:0] a, input logic [7:0] d, input logic ce_n = 1'b0);
    hm.access(a, 1'b1, d, ce_n, q);
  endtask
  task automatic hr(input logic [19:0] a);
    hm.access(a, 1'b0, 8'h00, 1'b0, q);
  endtask
  task automatic core_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    core_data_addr  = a;
    core_data_wdata = d;
    core_data_write = 1'b1;
    @(posedge clk);
    #1;
    core_data_write = 1'b0;
  endtask
  // counts pulse cycles on the chosen line and on any line at all
  task automatic pulse(input int n_exp, input int line);
    int on_line, any;
    on_line = 0;
    any = 0;
    core_wr(12'hFFE, 8'h33);
    // sample first: the pulse is already low when the core write returns
    repeat (30) begin
      if (irq_line_oe_n === ~(16'h0001 << line)) on_line++;
      if (irq_line_oe_n !== 16'hFFFF) any++;
      chk("irq_line_out", 20'h0, irq_line_out);
      @(posedge clk);
      #1;
    end
    chk("pulse_on_line", 20'(n_exp), 20'(on_line));
    chk("pulse_any", 20'(n_exp), 20'(any));
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    // whole sequence needs well under a thousand cycles; this is ample margin
    #200000;
    fails++;
    report_and_stop;
  end
  initial begin
    fails = 0;
    n_compared = 0;
    nrst = 1'b0;
    bus_reset_input = 1'b0;
    base_jumper_inputs = 4'h0;
    core_code_addr = 13'h0000;
    core_data_addr = 12'h000;
    core_data_write = 1'b0;
    core_data_wdata = 8'h00;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    chk("core_reset", 20'h1, core_reset);
    chk("irq_oe_n", 20'hFFFF, irq_line_oe_n);
    chk("data_oe_n", 20'h1, host_data_oe_n);
    for (int j = 0; j < 16; j++) begin
      base_jumper_inputs = j[3:0];
      base = {seg_tab[j], 12'h000};
      hw(base + 20'h20, 8'h40 + j[7:0]);
      hw((base ^ 20'h80000) + 20'h20, 8'hEE);
      hw(base + 20'h20, 8'hDD, 1'b1);
      hr((base ^ 20'h80000) + 20'h20);
      chk("oe_on_miss", 20'h0, hm.oe_seen);
      hr(base + 20'h20);
      chk("shared_rd", 20'(8'h40 + j[7:0]), q);
      chk("oe_on_hit", 20'h1, hm.oe_seen);
      core_data_addr = 12'h020;
      repeat (2) @(posedge clk);
      #1;
      chk("core_rd", 20'(8'h40 + j[7:0]), core_data_rdata);
    end
    base_jumper_inputs = 4'hA;
    base = 20'hD8000;
    hw(base, 8'h14);
    repeat (2) @(posedge clk);
    #1;
    chk("port1_bits", 20'h2, {port1_bit2_input, port1_bit1_input});
    chk("core_reset", 20'h1, core_reset);
    hr(base);
    chk("ctrl_rd", 20'h14, q);
    core_wr(12'h000, 8'h5A);
    chk("port1_bits", 20'h2, {port1_bit2_input, port1_bit1_input});
    hr(base);
    chk("ctrl_rd", 20'h5A, q);
    hw(base, 8'h10);
    hw(base + 20'h1000, 8'hC3);
    hw(base + 20'h2FFF, 8'h3C);
    hr(base + 20'h2FFF);
    chk("code_end", 20'h3C, q);
    hr(base + 20'h3000);
    chk("oe_beyond", 20'h0, hm.oe_seen);
    repeat (2) @(posedge clk);
    #1;
    chk("code_fetch", 20'hC3, core_code_data);
    hw(base, 8'h19);
    repeat (2) @(posedge clk);
    #1;
    chk("core_reset", 20'h0, core_reset);
    hw(base + 20'h1000, 8'h00);
    hr(base + 20'h1000);
    chk("oe_code_run", 20'h0, hm.oe_seen);
    chk("code_kept", 20'hC3, core_code_data);
    hw(base + 20'h100, 8'hA5);
    hr(base + 20'h100);
    chk("shared_run", 20'hA5, q);
    hw(base + 20'h1, 8'h15);
    pulse(PULSE, 5);
    pulse(0, 5);
    hr(base + 20'hFFE);
    chk("irq_value", 20'h33, q);
    pulse(PULSE, 5);
    hr(base + 20'hFFE);
    hw(base, 8'h11);
    pulse(0, 5);
    hw(base, 8'h19);
    hw(base + 20'h1, 8'h0F);
    pulse(0, 15);
    hw(base + 20'h1, 8'h1F);
    pulse(PULSE, 15);
    // a host read of 0xFFE after the pulse has ended must lift the lock
    hr(base + 20'hFFE);
    core_wr(12'hFFE, 8'h44);
    hr(base + 20'hFFE);
    chk("irq_value", 20'h44, q);
    pulse(PULSE, 15);
    // mode bits set so the bus reset clearing them is visible
    hw(base, 8'h17);
    repeat (2) @(posedge clk);
    #1;
    chk("port1_bits", 20'h3, {port1_bit2_input, port1_bit1_input});
    chk("core_reset", 20'h0, core_reset);
    @(posedge clk);
    #1 bus_reset_input = 1'b1;
    @(posedge clk);
    #1 bus_reset_input = 1'b0;
    repeat (6) @(posedge clk);
    chk("core_reset", 20'h1, core_reset);
    chk("port1_bits", 20'h0, {port1_bit2_input, port1_bit1_input});
    report_and_stop;
  end
endmodule // isa_shared_ram_host_port_test
`default_nettype wire
